/* rtl/rrx_exec.sv */
`timescale 1ns/100ps
`include "rrx_map.svh"
// executes the three returns and rotate-left-through-carry
module rrx_exec
    import rrx_pkg::*;
#(
    parameter int PCW = 15
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic push_i,
    input wire logic [PCW-1:0] push_addr_i,
    output logic [PCW-1:0] pc_o,
    output logic pc_load_o,
    output logic [7:0] wreg_o,
    output logic carry_o,
    output logic [7:0] interrupt_control_reg_o,
    output rrx_fwr_t file_wr_o,
    output logic busy_o
);
    // architectural state and the registered outputs
    rrx_state_t state_r;
    logic [PCW-1:0] top;
    // top is the stack's registered output; it moves only on a push or a pop
    logic carry_r;
    logic [7:0] wreg_r;
    logic [7:0] interrupt_control_reg_r;
    rrx_fwr_t fwr_r;
    logic [PCW-1:0] pc_r;
    logic pc_load_r;
    logic busy_r;

    // opcode field compare, shared by the two instructions that carry an operand
    function automatic logic rrx_op_hit(input logic [13:0] word, input logic [5:0] code);
        return word[13:8] == code;
    endfunction

    // nine-bit left rotate: carry out on top, old carry enters at bit 0
    function automatic logic [8:0] rrx_rotl(input logic [7:0] val, input logic cin);
        return {val, cin};
    endfunction

    // decode; the flush cycle ignores the prefetched word
    wire logic go = instr_valid_i && state_r == RRX_S_EXEC;
    wire logic is_irq_ret = go && instr_i == `RRX_OPC_IRQ_RET;
    wire logic is_sub_ret = go && instr_i == `RRX_OPC_SUB_RET;
    wire logic is_lit_ret = go && rrx_op_hit(instr_i, `RRX_OPC_LIT_RET);
    wire logic is_rot = go && rrx_op_hit(instr_i, `RRX_OPC_ROT_LEFT);
    wire logic is_ret = is_irq_ret || is_sub_ret || is_lit_ret;
    wire logic rot_dest = instr_i[7];
    wire logic [6:0] rot_addr = instr_i[6:0];
    wire logic [7:0] lit_val = instr_i[7:0];

    // rotate datapath; the carry lives here, so nothing else in the core moves it
    wire logic [8:0] rot_full = rrx_rotl(file_rdata_i, carry_r);
    wire logic [7:0] rot_res = rot_full[7:0];
    wire logic rot_cout = rot_full[8];

    // a push in the same cycle as a return wins and the pop is dropped;
    // the core must not stack a call on top of a return
    rrx_stack #(
        .DEPTH(`RRX_STACK_DEPTH),
        .AW(PCW)
    ) u_stack (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .push_i(push_i),
        .push_addr_i(push_addr_i),
        .pop_i(is_ret),
        .top_o(top)
    );

    // returns take an extra flush cycle, giving two in total; busy marks it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= RRX_S_EXEC;
            busy_r <= 1'b0;
        end else begin
            busy_r <= is_ret;
            unique case (state_r)
                RRX_S_EXEC: if (is_ret) state_r <= RRX_S_FLUSH;
                RRX_S_FLUSH: state_r <= RRX_S_EXEC;
            endcase
        end
    end

    // program counter taken from stack top before the pop lands
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pc_r <= '0;
            pc_load_r <= 1'b0;
        end else begin
            pc_load_r <= is_ret;
            if (is_ret) pc_r <= top;
        end
    end

    // working register and carry; a literal return and a rotate never meet
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wreg_r <= `RRX_WREG_RESET;
            carry_r <= `RRX_CARRY_RESET;
        end else begin
            if (is_lit_ret) wreg_r <= lit_val;
            else if (is_rot && !rot_dest) wreg_r <= rot_res;
            if (is_rot) carry_r <= rot_cout;
        end
    end

    // global irq enable is only ever set here; only reset clears it, also in this block
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            interrupt_control_reg_r <= `RRX_IRQ_CTRL_RESET;
        end else if (is_irq_ret) begin
            interrupt_control_reg_r[`RRX_GLOBAL_IRQ_ENABLE_POS] <= 1'b1;
        end
    end

    // file write only when destination bit is one; address and data ride along
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fwr_r <= '0;
        end else begin
            fwr_r.wr <= is_rot && rot_dest;
            fwr_r.addr <= rot_addr;
            fwr_r.data <= rot_res;
        end
    end

    // every output is a plain register copy
    assign pc_o = pc_r;
    assign pc_load_o = pc_load_r;
    assign wreg_o = wreg_r;
    assign carry_o = carry_r;
    assign interrupt_control_reg_o = interrupt_control_reg_r;
    assign file_wr_o = fwr_r;
    assign busy_o = busy_r;

    // checks on the return path
    // a return loads pc from the entry that was on top when it was taken
    a_ret_pc_load: assert property (@(posedge clk_i) disable iff (reset_i)
        is_ret |=> pc_load_o && pc_o == $past(top))
        else $error("return did not load pc from stack top");

    // exactly one busy cycle follows every return
    a_ret_two_cyc: assert property (@(posedge clk_i) disable iff (reset_i)
        is_ret |=> busy_o ##1 !busy_o)
        else $error("return not two cycles");

    // irq return turns the global irq enable on
    a_irq_en_set: assert property (@(posedge clk_i) disable iff (reset_i)
        is_irq_ret |=> interrupt_control_reg_o[`RRX_GLOBAL_IRQ_ENABLE_POS])
        else $error("global irq enable not set");

    // nothing but an irq return may raise the enable
    a_irq_en_source: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(interrupt_control_reg_o[`RRX_GLOBAL_IRQ_ENABLE_POS]) |-> $past(is_irq_ret))
        else $error("global irq enable raised without irq return");

    // subroutine return leaves carry and working register alone
    a_sub_ret_flags: assert property (@(posedge clk_i) disable iff (reset_i)
        is_sub_ret |=> $stable(carry_o) && $stable(wreg_o))
        else $error("subroutine return changed state");

    // subroutine return neither writes a file register nor enables irqs
    a_sub_no_wr: assert property (@(posedge clk_i) disable iff (reset_i)
        is_sub_ret |=> !file_wr_o.wr && $stable(interrupt_control_reg_o))
        else $error("subroutine return wrote state");

    // literal lands in the working register one cycle after the return
    a_lit_wreg: assert property (@(posedge clk_i) disable iff (reset_i)
        is_lit_ret |=> wreg_o == $past(instr_i[7:0]))
        else $error("literal not loaded");

    // literal return loads pc and frees the core after its second cycle
    a_lit_pc: assert property (@(posedge clk_i) disable iff (reset_i)
        is_lit_ret |=> pc_load_o ##1 !busy_o)
        else $error("literal return pc load missing");

    // literal return must not touch the irq enable
    a_lit_irq_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        is_lit_ret |=> $stable(interrupt_control_reg_o))
        else $error("literal return changed irq control");

    // the other returns keep the carry and write no file register
    a_ret_no_carry: assert property (@(posedge clk_i) disable iff (reset_i)
        is_irq_ret || is_lit_ret |=> $stable(carry_o) && !file_wr_o.wr)
        else $error("return changed carry or wrote a file register");

    // a word offered in the flush cycle leaves no trace
    a_busy_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
        busy_o && instr_valid_i |=> !pc_load_o && !file_wr_o.wr
            && $stable(wreg_o) && $stable(carry_o))
        else $error("instruction taken in flush cycle");

    // checks on the rotate path
    // rotate to the file register carries old carry into bit 0
    a_rot_result: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rot && rot_dest |=> file_wr_o.wr
            && file_wr_o.data == {$past(file_rdata_i[6:0]), $past(carry_r)})
        else $error("rotate result wrong");

    // rotate to the working register writes no file register
    a_rot_dest_w: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rot && !rot_dest |=> !file_wr_o.wr
            && wreg_o == {$past(file_rdata_i[6:0]), $past(carry_o)})
        else $error("rotate to working register wrong");

    // old bit 7 becomes carry, irq control untouched
    a_rot_carry: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rot |=> carry_o == $past(file_rdata_i[7]) && $stable(interrupt_control_reg_o))
        else $error("rotate carry wrong");

    // rotate is a single cycle and never moves the program counter
    a_rot_one_cyc: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rot |=> !pc_load_o && !busy_o)
        else $error("rotate took a return cycle");

    // write-back goes to the addressed register and keeps the working register
    a_rot_file_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        is_rot && rot_dest |=> file_wr_o.addr == $past(instr_i[6:0]) && $stable(wreg_o))
        else $error("rotate write-back address or working register wrong");
endmodule

/* rtl/rrx_map.svh */
// Overview of operation
// - irq return pops the stack into the program counter; one word, two cycles.
// - irq return also sets global irq enable, bit 7 of interrupt control.
// - subroutine return pops stack into program counter, two cycles, flags untouched.
// - literal return writes its 8-bit literal into the working register.
// - literal return also loads program counter from stack top; two cycles.
// - rotate left shifts addressed file register one place left through carry.
// - destination bit 0 writes working register, 1 writes back the file register.
`ifndef RRX_MAP_SVH
`define RRX_MAP_SVH
`define RRX_GLOBAL_IRQ_ENABLE_POS 7
`define RRX_WREG_RESET 8'h00
`define RRX_CARRY_RESET 1'b0
`define RRX_IRQ_CTRL_RESET 8'h00
`define RRX_RET_CYCLES 2
`define RRX_ROT_CYCLES 1
`define RRX_OPC_IRQ_RET 14'h0009
`define RRX_OPC_SUB_RET 14'h0008
`define RRX_OPC_LIT_RET 6'h34
`define RRX_OPC_ROT_LEFT 6'h0d
`define RRX_STACK_DEPTH 16
`endif

/* rtl/rrx_pkg.sv */
package rrx_pkg;
    typedef enum logic [1:0] {
        RRX_NONE,
        RRX_IRQ_RET,
        RRX_SUB_RET,
        RRX_LIT_RET
    } rrx_ret_t;
    // one register-file write request
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } rrx_fwr_t;
    typedef enum logic {
        RRX_S_EXEC,
        RRX_S_FLUSH
    } rrx_state_t;
endpackage

/* rtl/rrx_stack.sv */
`timescale 1ns/100ps
`include "rrx_map.svh"
// small hardware call stack; top of stack is held in a register
module rrx_stack #(
    parameter int DEPTH = `RRX_STACK_DEPTH,
    parameter int AW = 15
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic push_i,
    input wire logic [AW-1:0] push_addr_i,
    input wire logic pop_i,
    output logic [AW-1:0] top_o
);
    logic [AW-1:0] mem_r [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_r;
    logic [$clog2(DEPTH)-1:0] ptr_nxt;
    logic [$clog2(DEPTH)-1:0] ptr_dn;

    // the stack wraps silently on overflow, as a circular buffer
    assign ptr_nxt = ptr_r + 1'b1;
    assign ptr_dn = ptr_r - 1'b1;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptr_r <= '0;
            top_o <= '0;
        end else if (push_i) begin
            mem_r[ptr_nxt] <= push_addr_i;
            ptr_r <= ptr_nxt;
            top_o <= push_addr_i;
        end else if (pop_i) begin
            ptr_r <= ptr_dn;
            top_o <= mem_r[ptr_dn];
        end
    end
endmodule

/* sim/rrx_exec_tb_top.sv */
`timescale 1ns/100ps
module rrx_exec_tb_top;
    import rrx_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0] file_rdata_i = 8'h00;
    logic push_i = 1'b0;
    logic [14:0] push_addr_i = 15'h0000;
    logic [14:0] pc_o;
    logic pc_load_o;
    logic carry_o;
    logic busy_o;
    logic [7:0] wreg_o;
    logic [7:0] interrupt_control_reg_o;
    rrx_fwr_t file_wr_o;
    int failures = 0;
    int num_checks = 0;
    logic [14:0] stk[$];
    logic c_m = 1'b0;
    logic [7:0] w_m = 8'h00;
    logic [15:0] rv;
    always #50 clk_i = ~clk_i;
    rrx_exec i_rrx_exec (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .file_rdata_i(file_rdata_i), .push_i(push_i),
        .push_addr_i(push_addr_i), .pc_o(pc_o), .pc_load_o(pc_load_o), .wreg_o(wreg_o),
        .carry_o(carry_o), .interrupt_control_reg_o(interrupt_control_reg_o),
        .file_wr_o(file_wr_o), .busy_o(busy_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // new carry, result: the operand's top bit leaves, old carry enters at bit 0
    function automatic logic [8:0] rot(input logic [7:0] v, input logic c);
        return {v, c};
    endfunction
    // caller lowers valid, so back-to-back requests never toggle it in one step
    task automatic issue(input logic [13:0] op, input logic [7:0] rd);
        instr_valid_i = 1'b1;
        instr_i = op;
        file_rdata_i = rd;
        @(negedge clk_i);
    endtask
    task automatic rot_t(input logic d, input logic [6:0] f, input logic [7:0] rd);
        logic [8:0] r;
        r = rot(rd, c_m);
        issue({6'h0d, d, f}, rd);
        c_m = r[8];
        if (!d) w_m = r[7:0];
        chk(carry_o, c_m);
        chk(wreg_o, w_m);
        chk(file_wr_o, d ? {1'b1, f, r[7:0]} : {1'b0, file_wr_o[14:0]});
    endtask
    task automatic push(input logic [14:0] a);
        push_i = 1'b1;
        push_addr_i = a;
        stk.push_back(a);
        @(negedge clk_i);
        // caller lowers push once the last entry is in
    endtask
    // an instruction offered in the busy cycle must leave no trace
    task automatic ret(input logic [13:0] op, input logic [7:0] we, input logic [7:0] ie);
        logic [14:0] top;
        top = stk.pop_back();
        issue(op, 8'h00);
        instr_i = {6'h34, ~we};
        w_m = we;
        chk(pc_load_o, 16'h0001);
        chk(pc_o, top);
        chk(wreg_o, we);
        chk(interrupt_control_reg_o, ie);
        chk(carry_o, c_m);
        chk(busy_o, 16'h0001);
        @(negedge clk_i);
        chk({busy_o, pc_load_o, wreg_o}, {2'b00, we});
    endtask
    initial begin
        void'($urandom(88656));
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        rot_t(1'b0, 7'h05, 8'he6);
        rot_t(1'b1, 7'h7f, 8'h80);
        repeat (24) begin
            rv = 16'($urandom);
            rot_t(rv[15], rv[14:8], rv[7:0]);
        end
        instr_valid_i = 1'b0;
        $display("rotate test done");
        repeat (3) begin
            rv = 16'($urandom);
            push(rv[14:0]);
        end
        push_i = 1'b0;
        rv = 16'($urandom);
        ret({6'h34, rv[7:0]}, rv[7:0], 8'h00);
        ret(14'h0008, w_m, 8'h00);
        ret(14'h0009, w_m, 8'h80);
        instr_valid_i = 1'b0;
        $display("return test done");
        // mid-run reset must clear every output, carry and irq enable included
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(pc_o, 16'h0000);
        chk({pc_load_o, busy_o, carry_o, wreg_o}, 16'h0000);
        chk({interrupt_control_reg_o, 7'h00, file_wr_o.wr}, 16'h0000);
        reset_i = 1'b0;
        c_m = 1'b0;
        w_m = 8'h00;
        stk.delete();
        // a stale carry would show up in bit 0 of this result
        rot_t(1'b1, 7'h11, 8'h80);
        rot_t(1'b0, 7'h22, 8'h01);
        instr_valid_i = 1'b0;
        $display("reset test done");
        test_done();
    end
    // whole run is under a hundred cycles; a hang is cut at five hundred
    initial begin
        #(100 * 500);
        failures++;
        test_done();
    end
endmodule
